// ==== hw/bfx_regs.svh ====
// bfx register offsets, field positions, reset values and cycle counts
`ifndef BFX_REGS_SVH
`define BFX_REGS_SVH

`define BFX_OFF_INSTR      12'h000
`define BFX_OFF_STATUS_REGISTER       12'h004
`define BFX_OFF_PC         12'h008
`define BFX_OFF_STAT       12'h00C
`define BFX_OFF_RETIRED    12'h010
`define BFX_GPR_TAG        5'h02
`define BFX_IO_TAG         4'h2

`define BFX_STAT_BUSY      0
`define BFX_STAT_ILLEGAL   1

`define BFX_OP_MSB         15
`define BFX_OP_LSB         11
`define BFX_ADDR_MSB       10
`define BFX_ADDR_LSB       5
`define BFX_BIT_MSB        2
`define BFX_K_MSB          6

`define BFX_STATUS_REGISTER_RST       8'h00
`define BFX_PC_RST         16'h0000

`define BFX_CYC_BR_NT      2'h1
`define BFX_CYC_BR_TAKEN   2'h2
`define BFX_CYC_IO_CLR     2'h2
`define BFX_CYC_SIMPLE     2'h1

`endif

// ==== hw/bfx_pkg.sv ====
// bfx types: opcodes, states, status flags and the module state record
package bfx_pkg;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALFCARRY_SET,
        OP_BRANCH_HALFCARRY_CLEAR,
        OP_BRANCH_XFER_FLAG_SET,
        OP_BRANCH_XFER_FLAG_CLEAR,
        OP_BRANCH_OVERFLOW_SET,
        OP_BRANCH_OVERFLOW_CLEAR,
        OP_BRANCH_IRQ_ENABLED,
        OP_BRANCH_IRQ_DISABLED,
        OP_IO_BIT_CLEAR,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_BIT_TO_XFER_FLAG,
        OP_XFER_FLAG_TO_BIT,
        OP_OVERFLOW_FLAG_SET,
        OP_OVERFLOW_FLAG_CLEAR,
        OP_SIGNED_FLAG_SET,
        OP_SIGNED_FLAG_CLEAR,
        OP_HALFCARRY_FLAG_SET,
        OP_HALFCARRY_FLAG_CLEAR
    } bfx_op_e;

    typedef enum logic [1:0] {
        BFX_IDLE,
        BFX_EXEC,
        BFX_WAIT
    } bfx_state_e;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } bfx_status_register_s;

    typedef struct packed {
        logic [31:0][7:0] gpr;
        logic [63:0][7:0] io;
        bfx_status_register_s        status_register;
        logic [15:0]      pc;
        logic [15:0]      instr;
        logic [15:0]      retired;
        bfx_state_e       state;
        logic             busy;
        logic             illegal;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } bfx_state_s;

endpackage : bfx_pkg

// ==== hw/bfx_bitops.sv ====
// bfx branch condition and rotate-through-carry datapath
`timescale 1ns/10ps
`include "bfx_regs.svh"

module bfx_bitops
    import bfx_pkg::*;
(
    // instruction and operands
    input  wire logic      [4:0] op,
    input  wire logic      [7:0] operand,
    input  wire bfx_status_register_s       status_register_in,
    // results
    output logic                 take,
    output logic           [7:0] rot_res,
    output bfx_status_register_s            rot_status_register
);

    function automatic logic branch_cond(input bfx_op_e o, input bfx_status_register_s f);
        logic r;
        r = 1'b0;
        unique case (o)
            OP_BRANCH_SIGNED_GE:       r = ~(f.n ^ f.v);
            OP_BRANCH_SIGNED_LT:       r = f.n ^ f.v;
            OP_BRANCH_HALFCARRY_SET:   r = f.h;
            OP_BRANCH_HALFCARRY_CLEAR: r = ~f.h;
            OP_BRANCH_XFER_FLAG_SET:   r = f.t;
            OP_BRANCH_XFER_FLAG_CLEAR: r = ~f.t;
            OP_BRANCH_OVERFLOW_SET:    r = f.v;
            OP_BRANCH_OVERFLOW_CLEAR:  r = ~f.v;
            OP_BRANCH_IRQ_ENABLED:     r = f.i;
            OP_BRANCH_IRQ_DISABLED:    r = ~f.i;
            default:                   r = 1'b0;
        endcase
        return r;
    endfunction : branch_cond

    // {carry out, result}
    function automatic logic [8:0] rotate(input logic left, input logic cin,
                                          input logic [7:0] d);
        logic [8:0] r;
        r = left ? {d[7], d[6:0], cin} : {d[0], cin, d[7:1]};
        return r;
    endfunction : rotate

    logic       left_w;
    logic [8:0] rot_w;

    assign left_w = (bfx_op_e'(op) == OP_ROTATE_LEFT_CARRY);
    assign rot_w  = rotate(left_w, status_register_in.c, operand);      // see RULE8
    assign take   = branch_cond(bfx_op_e'(op), status_register_in);     // see RULE1
    assign rot_res = rot_w[7:0];

    // s, h, t, i are left as they were
    always_comb
    begin
        rot_status_register   = status_register_in;
        rot_status_register.c = rot_w[8];                               // see RULE9
        rot_status_register.z = (rot_w[7:0] == 8'h00);
        rot_status_register.n = rot_w[7];
        rot_status_register.v = rot_w[7] ^ rot_w[8];
    end

endmodule : bfx_bitops

// ==== hw/bfx_exec.sv ====
// bfx instruction executor for branches, bit, rotate and flag ops, APB slave
// Operation
// RULE1: signed ge branch taken when N xor V clear
// RULE2: signed lt branch taken when N xor V set
// RULE3: halfcarry branch pair tests H flag
// RULE4: transfer-flag branch pair tests T flag
// RULE5: overflow branch pair tests V flag
// RULE6: irq branch pair tests I flag
// RULE7: io bit clear zeroes one bit, two cycles
// RULE8: rotate left through carry, sets ZCNV
// RULE9: rotate right through carry, sets ZCNV
// RULE10: bit store copies register bit to T
// RULE11: bit load copies T into register bit
// RULE12: set or clear overflow flag only
// RULE13: set or clear signed flag only
// RULE14: set or clear halfcarry flag only
// RULE15: multi-cycle ops stall the next instruction
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "bfx_regs.svh"

module bfx_exec
    import bfx_pkg::*;
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core status
    output logic             exec_busy
);

    function automatic logic is_gpr(input logic [11:0] a);
        return (a[11:7] == `BFX_GPR_TAG) && (a[1:0] == 2'h0);
    endfunction : is_gpr

    function automatic logic is_io(input logic [11:0] a);
        return (a[11:8] == `BFX_IO_TAG) && (a[1:0] == 2'h0);
    endfunction : is_io

    bfx_state_s r;
    bfx_state_s n;

    bfx_op_e     op_w;
    logic [4:0]  gra_w;
    logic [5:0]  ioa_w;
    logic [2:0]  bit_w;
    logic [7:0]  mask_w;
    logic [7:0]  opnd_w;
    logic [15:0] pc_inc_w;
    logic [15:0] tgt_w;
    logic        take_w;
    logic        is_br_w;
    logic [7:0]  rot_res_w;
    bfx_status_register_s   rot_status_register_w;
    logic        acc_w;
    logic        ex_w;

    assign op_w     = bfx_op_e'(r.instr[`BFX_OP_MSB:`BFX_OP_LSB]);
    assign ioa_w    = r.instr[`BFX_ADDR_MSB:`BFX_ADDR_LSB];
    assign gra_w    = ioa_w[4:0];
    assign bit_w    = r.instr[`BFX_BIT_MSB:0];
    assign mask_w   = 8'h01 << bit_w;
    assign opnd_w   = r.gpr[gra_w];
    assign pc_inc_w = r.pc + 16'h0001;
    assign tgt_w    = pc_inc_w
                    + {{9{r.instr[`BFX_K_MSB]}}, r.instr[`BFX_K_MSB:0]};
    assign is_br_w  = (op_w >= OP_BRANCH_SIGNED_GE)
                    && (op_w <= OP_BRANCH_IRQ_DISABLED);
    assign acc_w    = psel && penable && !r.pready;
    assign ex_w     = ce && (r.state == BFX_EXEC);

    bfx_bitops u_bitops (
        .op       (r.instr[`BFX_OP_MSB:`BFX_OP_LSB]),
        .operand  (opnd_w),
        .status_register_in  (r.status_register),
        .take     (take_w),
        .rot_res  (rot_res_w),
        .rot_status_register (rot_status_register_w)
    );

    always_comb
    begin
        n         = r;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;

        // bus side; any write waits while an op is in flight
        if (acc_w && !(pwrite && r.state != BFX_IDLE))       // see RULE15
        begin
            n.pready = 1'b1;
            if (pwrite)
            begin
                if (paddr == `BFX_OFF_INSTR)
                begin
                    n.instr = pwdata[15:0];
                    n.state = BFX_EXEC;
                end
                else if (paddr == `BFX_OFF_STATUS_REGISTER)
                    n.status_register = bfx_status_register_s'(pwdata[7:0]);
                else if (paddr == `BFX_OFF_PC)
                    n.pc = pwdata[15:0];
                else if (paddr == `BFX_OFF_STAT)
                begin
                    if (pwdata[`BFX_STAT_ILLEGAL])
                        n.illegal = 1'b0;
                end
                else if (is_gpr(paddr))
                    n.gpr[paddr[6:2]] = pwdata[7:0];
                else if (is_io(paddr))
                    n.io[paddr[7:2]] = pwdata[7:0];
                else
                    n.pslverr = 1'b1;
            end
            else
            begin
                n.prdata = 32'h0000_0000;
                if (paddr == `BFX_OFF_INSTR)
                    n.prdata[15:0] = r.instr;
                else if (paddr == `BFX_OFF_STATUS_REGISTER)
                    n.prdata[7:0] = r.status_register;
                else if (paddr == `BFX_OFF_PC)
                    n.prdata[15:0] = r.pc;
                else if (paddr == `BFX_OFF_STAT)
                begin
                    n.prdata[`BFX_STAT_BUSY]    = r.busy;
                    n.prdata[`BFX_STAT_ILLEGAL] = r.illegal;
                end
                else if (paddr == `BFX_OFF_RETIRED)
                    n.prdata[15:0] = r.retired;
                else if (is_gpr(paddr))
                    n.prdata[7:0] = r.gpr[paddr[6:2]];
                else if (is_io(paddr))
                    n.prdata[7:0] = r.io[paddr[7:2]];
                else
                    n.pslverr = 1'b1;
            end
        end

        unique case (r.state)
            BFX_IDLE:
            begin
            end
            BFX_EXEC:
            begin
                n.retired = r.retired + 16'h0001;
                n.pc      = pc_inc_w;
                n.state   = (`BFX_CYC_SIMPLE == 2'h2) ? BFX_WAIT : BFX_IDLE;
                if (is_br_w)
                begin
                    // flags untouched on every branch
                    if (take_w)                     // see RULE2 RULE3 RULE5
                    begin
                        n.pc    = tgt_w;            // see RULE4 RULE6
                        n.state = (`BFX_CYC_BR_TAKEN == 2'h2)
                                ? BFX_WAIT : BFX_IDLE;
                    end
                    else
                        n.state = (`BFX_CYC_BR_NT == 2'h2)
                                ? BFX_WAIT : BFX_IDLE;
                end
                else
                begin
                    unique case (op_w)
                        OP_IO_BIT_CLEAR:
                        begin
                            n.io[ioa_w][bit_w] = 1'b0;           // see RULE7
                            n.state = (`BFX_CYC_IO_CLR == 2'h2)
                                    ? BFX_WAIT : BFX_IDLE;
                        end
                        OP_ROTATE_LEFT_CARRY,
                        OP_ROTATE_RIGHT_CARRY:
                        begin
                            n.gpr[gra_w] = rot_res_w;       // see RULE8
                            n.status_register       = rot_status_register_w;      // see RULE9
                        end
                        OP_BIT_TO_XFER_FLAG:
                            n.status_register.t = opnd_w[bit_w];       // see RULE10
                        OP_XFER_FLAG_TO_BIT:
                            n.gpr[gra_w][bit_w] = r.status_register.t; // see RULE11
                        OP_OVERFLOW_FLAG_SET:
                            n.status_register.v = 1'b1;                // see RULE12
                        OP_OVERFLOW_FLAG_CLEAR:
                            n.status_register.v = 1'b0;                // see RULE12
                        OP_SIGNED_FLAG_SET:
                            n.status_register.s = 1'b1;                // see RULE13
                        OP_SIGNED_FLAG_CLEAR:
                            n.status_register.s = 1'b0;                // see RULE13
                        OP_HALFCARRY_FLAG_SET:
                            n.status_register.h = 1'b1;                // see RULE14
                        OP_HALFCARRY_FLAG_CLEAR:
                            n.status_register.h = 1'b0;                // see RULE14
                        OP_NOP:
                        begin
                        end
                        // unknown code: skip it but leave a sticky trace
                        default:
                            n.illegal = 1'b1;
                    endcase
                end
            end
            // second cycle of a two-cycle op, no state changes
            BFX_WAIT:
                n.state = BFX_IDLE;                         // see RULE15
        endcase

        n.busy = (n.state != BFX_IDLE);
    end

    // all-zero reset: IDLE is the first enum member, flags and pc clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else if (ce)
            r <= n;
    end

    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign exec_busy = r.busy;

    logic [7:0] status_register_w;
    logic [7:0] io_cleared_w;
    logic [7:0] rol_exp_w;
    logic [7:0] ror_exp_w;
    logic       selbit_w;

    assign status_register_w       = r.status_register;
    assign io_cleared_w = r.io[ioa_w] & ~mask_w;
    assign rol_exp_w    = {opnd_w[6:0], r.status_register.c};
    assign ror_exp_w    = {r.status_register.c, opnd_w[7:1]};
    assign selbit_w     = opnd_w[bit_w];

    sequence s_branch_taken;
        ex_w && is_br_w && take_w;
    endsequence

    sequence s_extra_cycle;
        r.state == BFX_WAIT;
    endsequence

    property p_br_ge;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_BRANCH_SIGNED_GE && !(r.status_register.n ^ r.status_register.v)
        |=> r.pc == $past(tgt_w);
    endproperty
    a_br_ge: assert property (p_br_ge)                            // see RULE1
        else $error("signed ge branch did not jump");

    property p_br_lt_nt;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_BRANCH_SIGNED_LT && !(r.status_register.n ^ r.status_register.v)
        |=> r.pc == $past(pc_inc_w) && r.state == BFX_IDLE;
    endproperty
    a_br_lt_nt: assert property (p_br_lt_nt)                      // see RULE2
        else $error("signed lt branch not sequential");

    property p_br_hs;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_BRANCH_HALFCARRY_SET && r.status_register.h
        |=> r.pc == $past(tgt_w);
    endproperty
    a_br_hs: assert property (p_br_hs)                            // see RULE3
        else $error("halfcarry set branch did not jump");

    property p_br_flags;
        @(posedge pclk) disable iff (!presetn)
        ex_w && is_br_w |=> $stable(status_register_w);
    endproperty
    a_br_flags: assert property (p_br_flags)                      // see RULE4
        else $error("branch changed status flags");

    property p_taken_two;
        @(posedge pclk) disable iff (!presetn)
        s_branch_taken |=> s_extra_cycle;
    endproperty
    a_taken_two: assert property (p_taken_two)                    // see RULE5
        else $error("taken branch did not take a second cycle");

    property p_io_clr;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_IO_BIT_CLEAR
        |=> (r.io[$past(ioa_w)] == $past(io_cleared_w)) and s_extra_cycle;
    endproperty
    a_io_clr: assert property (p_io_clr)                          // see RULE7
        else $error("io bit clear wrong");

    property p_rol;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_ROTATE_LEFT_CARRY
        |=> r.gpr[$past(gra_w)] == $past(rol_exp_w)
            && r.status_register.c == $past(opnd_w[7]);
    endproperty
    a_rol: assert property (p_rol)                                // see RULE8
        else $error("rotate left result wrong");

    property p_ror;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_ROTATE_RIGHT_CARRY
        |=> r.gpr[$past(gra_w)] == $past(ror_exp_w)
            && r.status_register.c == $past(opnd_w[0]);
    endproperty
    a_ror: assert property (p_ror)                                // see RULE9
        else $error("rotate right result wrong");

    property p_bst;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_BIT_TO_XFER_FLAG
        |=> r.status_register.t == $past(selbit_w)
            && (status_register_w & 8'hBF) == ($past(status_register_w) & 8'hBF);
    endproperty
    a_bst: assert property (p_bst)                                // see RULE10
        else $error("bit store to transfer flag wrong");

    property p_sev;
        @(posedge pclk) disable iff (!presetn)
        ex_w && op_w == OP_OVERFLOW_FLAG_SET
        |=> r.status_register.v && (status_register_w & 8'hF7) == ($past(status_register_w) & 8'hF7);
    endproperty
    a_sev: assert property (p_sev)                                // see RULE12
        else $error("overflow set touched other flags");

    property p_busy_stall;
        @(posedge pclk) disable iff (!presetn)
        ce && psel && penable && pwrite && r.state != BFX_IDLE
        |=> !pready;
    endproperty
    a_busy_stall: assert property (p_busy_stall)                  // see RULE15
        else $error("write accepted while op in flight");

endmodule : bfx_exec

// ==== tb/branch_bit_flag_instr_exec_bench.sv ====
// randomised self-checking bench for the bfx instruction executor
`timescale 1ns/10ps
`include "bfx_regs.svh"

module branch_bit_flag_instr_exec_bench
    import bfx_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        exec_busy;
    logic [31:0] seed;
    int          fail_count;
    int          n_tests;
    int          n_exec;

    bfx_exec dut_u (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .exec_busy (exec_busy)
    );

    always #12.5 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask : check

    // request held until pready is seen at a rising edge; only the
    // watchdog ends a wait that never gets an answer
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd

    // busy cycles counted from the cycle after the INSTR write is answered
    task automatic exec(input logic [15:0] ins, output int cyc);
        wr(`BFX_OFF_INSTR, {16'h0000, ins});
        n_exec++;
        cyc = 1;
        #1;
        while (exec_busy === 1'b1 && cyc < 8)
        begin
            @(posedge pclk);
            #1;
            cyc++;
        end
    endtask : exec

    // status_register bits: i7 t6 h5 s4 v3 n2 z1 c0
    task automatic model(input logic [15:0] ins, input logic [7:0] sr,
                         input logic [15:0] pc, input logic [7:0] r,
                         input logic [7:0] io, output logic [7:0] esr,
                         output logic [15:0] epc, output logic [7:0] er,
                         output logic [7:0] eio, output int cyc,
                         output logic ill);
        logic [4:0]  op;
        logic [2:0]  b;
        logic [15:0] k;
        logic        tk;
        op = ins[15:11];
        b = ins[2:0];
        k = {{9{ins[6]}}, ins[6:0]};
        esr = sr;
        er = r;
        eio = io;
        epc = pc + 16'h0001;
        cyc = 1;
        ill = 1'b0;
        tk = 1'b0;
        case (op)
            5'd0: ;
            5'd1: tk = ~(sr[2] ^ sr[3]);
            5'd2: tk = sr[2] ^ sr[3];
            5'd3: tk = sr[5];
            5'd4: tk = ~sr[5];
            5'd5: tk = sr[6];
            5'd6: tk = ~sr[6];
            5'd7: tk = sr[3];
            5'd8: tk = ~sr[3];
            5'd9: tk = sr[7];
            5'd10: tk = ~sr[7];
            5'd11:
            begin
                eio[b] = 1'b0;
                cyc = 2;
            end
            5'd12:
            begin
                er = {r[6:0], sr[0]};
                esr[0] = r[7];
            end
            5'd13:
            begin
                er = {sr[0], r[7:1]};
                esr[0] = r[0];
            end
            5'd14: esr[6] = r[b];
            5'd15: er[b] = sr[6];
            5'd16: esr[3] = 1'b1;
            5'd17: esr[3] = 1'b0;
            5'd18: esr[4] = 1'b1;
            5'd19: esr[4] = 1'b0;
            5'd20: esr[5] = 1'b1;
            5'd21: esr[5] = 1'b0;
            default: ill = 1'b1;
        endcase
        if (op == 5'd12 || op == 5'd13)
        begin
            esr[1] = (er == 8'h00);
            esr[2] = er[7];
            esr[3] = er[7] ^ esr[0];
        end
        if (tk)
        begin
            epc = pc + 16'h0001 + k;
            cyc = 2;
        end
    endtask : model

    initial
    begin
        #(25 * 40000);
        fail_count++;
        conclude();
    end

    initial
    begin
        logic [31:0] r;
        logic [31:0] q;
        logic [15:0] ins;
        logic [15:0] pc;
        logic [15:0] epc;
        logic [7:0]  sr;
        logic [7:0]  gv;
        logic [7:0]  iv;
        logic [7:0]  esr;
        logic [7:0]  er;
        logic [7:0]  eio;
        logic [5:0]  idx;
        logic [4:0]  op;
        logic [11:0] ga;
        logic [11:0] ia;
        logic        ill;
        logic        e;
        int          cyc;
        int          ecyc;
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        seed = 32'h0000_DFB5;
        fail_count = 0;
        n_tests = 0;
        n_exec = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`BFX_OFF_STATUS_REGISTER, q);
        check(q, {24'h0, `BFX_STATUS_REGISTER_RST});
        rd(`BFX_OFF_PC, q);
        check(q, {16'h0, `BFX_PC_RST});
        rd(`BFX_OFF_RETIRED, q);
        check(q, 32'h0000_0000);
        apb(1'b1, `BFX_OFF_RETIRED, 32'h0000_0005, q, e);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b0, 12'h300, 32'h0000_0000, q, e);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b0, 12'h101, 32'h0000_0000, q, e);
        check({31'h0, e}, 32'h0000_0001);
        for (int i = 0; i < 240; i++)
        begin
            r = xs();
            // first two passes walk opcodes 0 to 23 in order, illegal 22 and 23 too
            op = (i < 48) ? 5'(i % 24) : r[31:27];
            ins = {op, r[10:0]};
            pc = r[26:11];
            if (i < 48 && (op == 5'd1 || op == 5'd2))
            begin
                ins[6:0] = (i < 24) ? 7'h40 : 7'h3F;
                pc = (i < 24) ? 16'h0000 : 16'hFFFF;
            end
            r = xs();
            sr = r[7:0];
            gv = r[15:8];
            iv = r[23:16];
            idx = ins[10:5];
            ga = 12'h100 + {5'h00, idx[4:0], 2'b00};
            ia = 12'h200 + {4'h0, idx, 2'b00};
            wr(`BFX_OFF_STATUS_REGISTER, {r[31:24], sr});
            wr(`BFX_OFF_PC, {16'h0000, pc});
            wr(ga, {24'h0, gv});
            wr(ia, {24'h0, iv});
            model(ins, sr, pc, gv, iv, esr, epc, er, eio, ecyc, ill);
            exec(ins, cyc);
            check(32'(cyc), 32'(ecyc));
            rd(`BFX_OFF_STATUS_REGISTER, q);
            check(q, {24'h0, esr});
            rd(`BFX_OFF_PC, q);
            check(q, {16'h0, epc});
            rd(ga, q);
            check(q, {24'h0, er});
            rd(ia, q);
            check(q, {24'h0, eio});
            rd(`BFX_OFF_STAT, q);
            check(q, {30'h0, ill, 1'b0});
            if (ill)
                wr(`BFX_OFF_STAT, 32'h0000_0002);
        end
        rd(`BFX_OFF_INSTR, q);
        check(q, {16'h0, ins});
        rd(`BFX_OFF_RETIRED, q);
        check(q, 32'(n_exec[15:0]));
        conclude();
    end

endmodule : branch_bit_flag_instr_exec_bench
